// ---- rtl/exp_link_monitor.sv ----
// Purpose: Base-unit side of the serial expansion link: presence check,
//          input/output image exchange, link-down handling, health input
// Assumes: Link pins and cycle_start_i are synchronous to clock_i
// Notes:   Zero-wait AHB-Lite slave; one interrupt line
//
// Added by the designer: the AHB-Lite slave port and the address map.
`include "exp_link_regs.svh"

// Behaviour
// - Check peer presence once per program cycle
// - Exchange images over two-way serial link
// - No input debounce on expansion inputs
// - Local inputs reach image within 30 ms
// - Local coils sent within 15 ms
// - Remote inputs reach image within 80 ms
// - Remote coils sent within 40 ms
// - Link down forces inputs and alarms zero
// - Health input 0 functional, 1 not
// - Health reads 1 until peer comes up
// - Twelve expansion input contacts presented
// - Eight coils; unused ones act as markers
// - Two group-fault alarm inputs presented
// - Alarm is 1 when group has fault
module exp_link_monitor
	import exp_link_pkg::*;
#(
	parameter int unsigned PHYS_OUTPUTS = 8,
	parameter logic [15:0] BIT_CYC = 16'(`EXP_BIT_CYC),
	parameter int unsigned IN_LOCAL_CYC = `EXP_IN_LOCAL_MS * `EXP_CYC_PER_MS,
	parameter int unsigned IN_REMOTE_CYC =
		`EXP_IN_REMOTE_MS * `EXP_CYC_PER_MS,
	parameter int unsigned OUT_LOCAL_CYC =
		`EXP_OUT_LOCAL_MS * `EXP_CYC_PER_MS,
	parameter int unsigned OUT_REMOTE_CYC =
		`EXP_OUT_REMOTE_MS * `EXP_CYC_PER_MS
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic cycle_start_i,
	input wire logic link_rx_i,
	output logic link_tx_o,
	output logic [11:0] expansion_input_o,
	output logic expansion_group_fault_hi_o,
	output logic expansion_group_fault_lo_o,
	output logic expansion_health_input_o,
	output logic irq_o
);

	// Coils beyond the fitted outputs are never sent, so they stay markers
	localparam logic [7:0] PHYS_MASK =
		8'((32'd1 << PHYS_OUTPUTS) - 32'd1);
	// Gap between frame starts leaves room for the frame itself
	localparam logic [31:0] FRAME_CYC = 32'(`EXP_TX_BITS) * 32'(BIT_CYC);
	localparam logic [31:0] GAP_LOCAL = 32'(OUT_LOCAL_CYC) - FRAME_CYC;
	localparam logic [31:0] GAP_REMOTE = 32'(OUT_REMOTE_CYC) - FRAME_CYC;
	// Stale limit counts from the end of the last good frame
	localparam logic [31:0] RXF_CYC = 32'(`EXP_RX_BITS) * 32'(BIT_CYC);
	localparam logic [31:0] STALE_LOCAL = 32'(IN_LOCAL_CYC) - RXF_CYC;
	localparam logic [31:0] STALE_REMOTE = 32'(IN_REMOTE_CYC) - RXF_CYC;

	exp_state_s st_ff;
	exp_state_s nxt_st;
	logic frame_ok;
	logic frame_err;
	logic seen_now;
	logic stale_hit;
	logic [7:0] sent_coils;
	logic [2:0] ev_set;
	logic [2:0] w1c;

	// Outputs other than hresp_o, which is tied low, come straight from the state register
	assign hrdata_o = st_ff.hrdata;
	assign hreadyout_o = st_ff.hready;
	assign hresp_o = 1'b0;
	assign link_tx_o = st_ff.tx_sh[0];
	assign expansion_input_o = st_ff.img;
	assign expansion_group_fault_hi_o = st_ff.fault_hi;
	assign expansion_group_fault_lo_o = st_ff.fault_lo;
	assign expansion_health_input_o = st_ff.health;
	assign irq_o = st_ff.irq;

	// Read mux for the address phase; unmapped words read zero
	function automatic logic [31:0] rd_word(input exp_state_s s,
		input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			`EXP_OFF_CTRL: begin
				w[`EXP_CTRL_REMOTE] = s.remote;
				w[`EXP_CTRL_TMO_MSB:`EXP_CTRL_TMO_LSB] = s.timeout;
			end
			`EXP_OFF_COILS: w[7:0] = s.coils;
			`EXP_OFF_IMAGE: begin
				w[11:0] = s.img;
				w[`EXP_IMG_FLT_HI] = s.fault_hi;
				w[`EXP_IMG_FLT_LO] = s.fault_lo;
				w[`EXP_IMG_HEALTH] = s.health;
				w[`EXP_IMG_LINK] = s.link_up;
			end
			`EXP_OFF_STATUS: w[2:0] = s.status;
			`EXP_OFF_MASK: w[2:0] = s.mask;
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// Whole next-state computation
	always_comb begin
		nxt_st = st_ff;
		frame_ok = 1'b0;
		frame_err = 1'b0;
		w1c = 3'h0;
		sent_coils = st_ff.coils & PHYS_MASK;

		// Receiver: raw line, no debounce stage in the path
		case (st_ff.rx_st)
			RX_IDLE: begin
				if (!link_rx_i) begin
					nxt_st.rx_st = RX_START;
					nxt_st.rx_tmr = BIT_CYC >> 1;
				end
			end
			RX_START: begin
				if (st_ff.rx_tmr != 16'h0000) begin
					nxt_st.rx_tmr = st_ff.rx_tmr - 16'h0001;
				end else if (!link_rx_i) begin
					nxt_st.rx_st = RX_DATA;
					nxt_st.rx_tmr = BIT_CYC - 16'h0001;
					nxt_st.rx_idx = 5'h00;
				end else begin
					nxt_st.rx_st = RX_IDLE; // Glitch, not a start bit
				end
			end
			RX_DATA: begin
				if (st_ff.rx_tmr != 16'h0000) begin
					nxt_st.rx_tmr = st_ff.rx_tmr - 16'h0001;
				end else begin
					nxt_st.rx_tmr = BIT_CYC - 16'h0001;
					if (st_ff.rx_idx == 5'h0F) begin
						nxt_st.rx_st = RX_IDLE;
						// Stop bit high and even parity make a good frame
						frame_ok = link_rx_i & ~(^st_ff.rx_sh);
						frame_err = ~frame_ok;
					end else begin
						nxt_st.rx_sh = {link_rx_i, st_ff.rx_sh[14:1]};
						nxt_st.rx_idx = st_ff.rx_idx + 5'h01;
					end
				end
			end
			default: nxt_st.rx_st = RX_IDLE;
		endcase
		if (frame_ok) begin
			nxt_st.rx_data = st_ff.rx_sh[13:0];
		end

		// Presence check, once per program cycle
		seen_now = st_ff.rx_seen | frame_ok;
		if (frame_ok) begin
			nxt_st.rx_seen = 1'b1;
			nxt_st.link_up = 1'b1;
		end else if (cycle_start_i) begin
			nxt_st.rx_seen = 1'b0;
		end
		if (cycle_start_i) begin
			if (seen_now) begin
				nxt_st.miss = 8'h00;
			end else begin
				if (st_ff.miss != 8'hFF) begin
					nxt_st.miss = st_ff.miss + 8'h01;
				end
				// Timeout of zero disables the missed-cycle check
				if (st_ff.timeout != 8'h00 &&
					st_ff.miss + 8'h01 >= st_ff.timeout) begin
					nxt_st.link_up = 1'b0;
				end
			end
		end

		// Input data older than the latency budget is no longer trusted
		stale_hit = st_ff.stale >=
			(st_ff.remote ? STALE_REMOTE : STALE_LOCAL);
		if (frame_ok) begin
			nxt_st.stale = 32'h0000_0000;
		end else if (!stale_hit) begin
			nxt_st.stale = st_ff.stale + 32'h0000_0001;
		end else begin
			nxt_st.link_up = 1'b0;
		end

		// Program image: zeroed while the link is down, else frozen between cycle starts
		if (!nxt_st.link_up) begin
			nxt_st.img = 12'h000;
			nxt_st.fault_hi = 1'b0;
			nxt_st.fault_lo = 1'b0;
		end else if (cycle_start_i) begin
			nxt_st.img = st_ff.rx_data[11:0];
			nxt_st.fault_hi = st_ff.rx_data[12];
			nxt_st.fault_lo = st_ff.rx_data[13];
		end
		nxt_st.health = ~nxt_st.link_up;

		// Transmitter: periodic coil frames, idle line high
		if (st_ff.tx_busy) begin
			if (st_ff.tx_tmr != 16'h0000) begin
				nxt_st.tx_tmr = st_ff.tx_tmr - 16'h0001;
			end else begin
				nxt_st.tx_tmr = BIT_CYC - 16'h0001;
				nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
				nxt_st.tx_idx = st_ff.tx_idx + 4'h1;
				if (st_ff.tx_idx == 4'(`EXP_TX_BITS - 1)) begin
					nxt_st.tx_busy = 1'b0;
				end
			end
		end
		if (st_ff.tx_gap != 32'h0000_0000) begin
			nxt_st.tx_gap = st_ff.tx_gap - 32'h0000_0001;
		end else if (!st_ff.tx_busy) begin
			// Gap plus frame stays inside the output budget
			nxt_st.tx_gap = st_ff.remote ? GAP_REMOTE : GAP_LOCAL;
			nxt_st.tx_busy = 1'b1;
			nxt_st.tx_idx = 4'h0;
			nxt_st.tx_tmr = BIT_CYC - 16'h0001;
			nxt_st.tx_sh = {1'b1, ^sent_coils, sent_coils, 1'b0};
		end

		// AHB-Lite: data-phase write, then address-phase capture
		if (st_ff.hwr) begin
			case (st_ff.haddr)
				`EXP_OFF_CTRL: begin
					nxt_st.remote = hwdata_i[`EXP_CTRL_REMOTE];
					nxt_st.timeout =
						hwdata_i[`EXP_CTRL_TMO_MSB:`EXP_CTRL_TMO_LSB];
				end
				`EXP_OFF_COILS: nxt_st.coils = hwdata_i[7:0];
				`EXP_OFF_STATUS: w1c = hwdata_i[2:0];
				`EXP_OFF_MASK: nxt_st.mask = hwdata_i[2:0];
				default: nxt_st.hwr = 1'b0; // Ignored, still OKAY
			endcase
		end
		nxt_st.hwr = 1'b0;
		if (hsel_i && htrans_i[1] && hready_i) begin
			nxt_st.hwr = hwrite_i;
			nxt_st.haddr = {haddr_i[7:2], 2'b00};
			if (!hwrite_i) begin
				nxt_st.hrdata = rd_word(st_ff, {haddr_i[7:2], 2'b00});
			end
		end
		nxt_st.hready = 1'b1;

		// Sticky events; a set in the clearing cycle survives
		ev_set = 3'h0;
		ev_set[`EXP_ST_LOST] = st_ff.link_up & ~nxt_st.link_up;
		ev_set[`EXP_ST_UP] = ~st_ff.link_up & nxt_st.link_up;
		ev_set[`EXP_ST_ERR] = frame_err;
		nxt_st.status = (st_ff.status & ~w1c) | ev_set;
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
	end

	// State register; reset leaves the link down and the line idle
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st_ff <= '0;
			st_ff.tx_sh <= 11'h7FF;
			st_ff.tx_gap <= 32'h0000_0000;
			st_ff.timeout <= `EXP_TMO_RESET;
			st_ff.health <= 1'b1;
			st_ff.hready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence s_tx_begin;
		!st_ff.tx_busy ##1 st_ff.tx_busy;
	endsequence

	sequence s_cycle_up;
		cycle_start_i ##1 st_ff.link_up;
	endsequence

	a_health_mirror: assert property (
		expansion_health_input_o == !st_ff.link_up)
		else $error("health input disagrees with link state");

	a_down_zero: assert property (
		!st_ff.link_up |-> expansion_input_o == 12'h000 &&
		!expansion_group_fault_hi_o && !expansion_group_fault_lo_o)
		else $error("inputs not zero while link down");

	a_img_hold: assert property (
		!$past(cycle_start_i) && $past(st_ff.link_up) && st_ff.link_up
		|-> $stable(expansion_input_o))
		else $error("input image changed inside a cycle");

	a_img_load: assert property (
		s_cycle_up |-> expansion_input_o == $past(st_ff.rx_data[11:0])
		&& expansion_group_fault_hi_o == $past(st_ff.rx_data[12])
		&& expansion_group_fault_lo_o == $past(st_ff.rx_data[13]))
		else $error("input image not loaded at cycle start");

	a_no_spurious_up: assert property (
		!st_ff.link_up && !frame_ok |=> !st_ff.link_up)
		else $error("link came up without a valid frame");

	a_miss_down: assert property (
		cycle_start_i && !seen_now && st_ff.timeout != 8'h00 &&
		st_ff.miss + 8'h01 >= st_ff.timeout |=> !st_ff.link_up)
		else $error("link not dropped after missed cycles");

	a_tx_start_bit: assert property (
		s_tx_begin |-> !link_tx_o ##1 !link_tx_o)
		else $error("frame did not open with a start bit");

	a_tx_idle_high: assert property (
		!st_ff.tx_busy |-> link_tx_o)
		else $error("link line not idle high between frames");

	a_stale_down: assert property (
		stale_hit && !frame_ok |=> !st_ff.link_up)
		else $error("stale input data kept link up");

	// Set beats a same-cycle clear, so no error is lost
	a_err_sticky: assert property (
		frame_err |=> st_ff.status[`EXP_ST_ERR])
		else $error("frame error not recorded in status");

	a_irq_level: assert property (
		irq_o == |(st_ff.status & st_ff.mask))
		else $error("interrupt does not follow masked status");

endmodule // exp_link_monitor

// ---- rtl/exp_link_regs.svh ----
// Purpose: Offsets, field positions, reset values and times of the link
//          monitor
// Assumes: 32-bit AHB-Lite register words, byte addresses below
// Notes:   Times are in ms; cycle counts derive from the clock rate
`ifndef EXP_LINK_REGS_SVH
`define EXP_LINK_REGS_SVH

// Register byte offsets
`define EXP_OFF_CTRL 8'h00
`define EXP_OFF_COILS 8'h04
`define EXP_OFF_IMAGE 8'h08
`define EXP_OFF_STATUS 8'h0C
`define EXP_OFF_MASK 8'h10

// Control fields
`define EXP_CTRL_REMOTE 0
`define EXP_CTRL_TMO_LSB 8
`define EXP_CTRL_TMO_MSB 15
`define EXP_TMO_RESET 8'h03

// Image fields
`define EXP_IMG_FLT_HI 12
`define EXP_IMG_FLT_LO 13
`define EXP_IMG_HEALTH 16
`define EXP_IMG_LINK 17

// Status and mask fields
`define EXP_ST_LOST 0
`define EXP_ST_UP 1
`define EXP_ST_ERR 2

// Timing
`define EXP_CLK_MHZ 200
`define EXP_CYC_PER_MS (`EXP_CLK_MHZ * 1000)
`define EXP_IN_LOCAL_MS 30
`define EXP_OUT_LOCAL_MS 15
`define EXP_IN_REMOTE_MS 80
`define EXP_OUT_REMOTE_MS 40
`define EXP_BIT_CYC 100

// Frame lengths in bits: start, payload, parity, stop
`define EXP_RX_BITS 17
`define EXP_TX_BITS 11

`endif

// ---- rtl/exp_link_pkg.sv ----
// Purpose: Types of the expansion link monitor
// Assumes: Used together with exp_link_regs.svh
// Notes:   Whole block state is one packed struct
package exp_link_pkg;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} exp_rx_e;

	typedef struct packed {
		exp_rx_e rx_st;
		logic [15:0] rx_tmr;
		logic [4:0] rx_idx;
		logic [14:0] rx_sh;
		logic [13:0] rx_data;
		logic rx_seen;
		logic [31:0] stale;
		logic tx_busy;
		logic [15:0] tx_tmr;
		logic [3:0] tx_idx;
		logic [10:0] tx_sh;
		logic [31:0] tx_gap;
		logic [7:0] miss;
		logic link_up;
		logic [11:0] img;
		logic fault_hi;
		logic fault_lo;
		logic health;
		logic remote;
		logic [7:0] timeout;
		logic [7:0] coils;
		logic [2:0] status;
		logic [2:0] mask;
		logic irq;
		logic [31:0] hrdata;
		logic [7:0] haddr;
		logic hwr;
		logic hready;
	} exp_state_s;

endpackage

// ---- sim/exp_peer_model.sv ----
// Purpose: Behavioural expansion unit at the far end of the serial link
// Assumes: Line idles high through a pull-up while the unit is off
// Notes:   Frames are 17 bits out and 11 bits in, LSB first
module exp_peer_model #(
	parameter int BIT_CYC = 4,
	parameter int GAP = 300
) (
	input wire logic clock_i,
	input wire logic on_i,
	input wire logic bad_par_i,
	input wire logic [13:0] data_i,
	input wire logic line_i,
	output logic line_o,
	output logic [7:0] coils_o,
	output logic bad_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial coils_o = 8'h00;
	initial bad_o = 1'b0;

	// Input frame: start, data, even parity, stop; parity broken on demand
	always begin : send
		logic [16:0] f;
		logic en;
		line_o <= 1'b1;
		repeat (GAP) @(posedge clock_i);
		// Power state taken per frame, so no frame is ever cut short
		en = on_i;
		f = {1'b1, ^data_i ^ bad_par_i, data_i, 1'b0};
		for (int i = 0; i < 17; i++) begin
			line_o <= en ? f[i] : 1'b1; // Pull-up while unit is off
			repeat (BIT_CYC) @(posedge clock_i);
		end
	end

	// Coil frame: sampled mid-bit, kept only when parity and stop hold
	always begin : recv
		logic [10:0] r;
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge clock_i);
		for (int i = 0; i < 11; i++) begin
			r[i] = line_i;
			repeat (BIT_CYC) @(posedge clock_i);
		end
		if (r[10] && !r[0] && !(^r[9:1])) coils_o <= r[8:1];
		else bad_o <= 1'b1;
	end
endmodule // exp_peer_model

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the expansion link monitor
// Assumes: Link times shortened through the design parameters
// Notes:   Program cycle is 400 clocks, peer frame every 368 clocks
`include "exp_link_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0;
	logic cycle_start_i = 1'b0;
	logic on = 1'b0;
	logic bad = 1'b0;
	logic [13:0] data = 14'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, link_rx_i, link_tx_o, irq_o, peer_bad;
	logic [11:0] expansion_input_o;
	logic expansion_group_fault_hi_o, expansion_group_fault_lo_o;
	logic expansion_health_input_o;
	logic [7:0] peer_coils;
	logic [8:0] cnt = 9'h0;
	logic [11:0] prev_in = 12'h0;
	logic prev_cs = 1'b0;
	int errors = 0;
	int n_tests = 0;
	wire logic hready_i = hreadyout_o;
	wire logic [22:0] st = {expansion_health_input_o,
		expansion_group_fault_lo_o, expansion_group_fault_hi_o,
		expansion_input_o, peer_coils};

	exp_link_monitor #(.BIT_CYC(16'h0004), .IN_LOCAL_CYC(2000),
		.IN_REMOTE_CYC(4000), .OUT_LOCAL_CYC(200), .OUT_REMOTE_CYC(400))
		dut_u (.clock_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
		.cycle_start_i, .link_rx_i, .link_tx_o, .expansion_input_o,
		.expansion_group_fault_hi_o, .expansion_group_fault_lo_o,
		.expansion_health_input_o, .irq_o);

	exp_peer_model peer_u (.clock_i, .on_i(on), .bad_par_i(bad),
		.data_i(data), .line_i(link_tx_o), .line_o(link_rx_i),
		.coils_o(peer_coils), .bad_o(peer_bad));

	always #2.5 clock_i = ~clock_i;

	// Program cycle tick, one clock wide
	always @(posedge clock_i) begin
		cnt <= (cnt == 9'd399) ? 9'h0 : cnt + 9'h1;
		cycle_start_i <= (cnt == 9'd399);
	end

	// Image may move while the link is up only after a cycle tick
	always @(negedge clock_i) begin
		if (!reset_i && expansion_input_o !== prev_in && !prev_cs &&
			expansion_health_input_o === 1'b0) begin
			errors++;
			$display("CHECK FAILED image hold exp %h got %h", prev_in,
				expansion_input_o);
		end
		prev_in <= expansion_input_o;
		prev_cs <= cycle_start_i;
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Single word transfer; waits on hready under a bound
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		htrans_i <= 2'h2;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1 && ++n < 50);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1 && ++n < 50);
		rd = hrdata_o;
		chk("ahb wait", 32'h0, {31'h0, n >= 50});
	endtask

	// Bounded wait for the masked port state, then one compare
	task wait_st(input logic [22:0] want, input logic [22:0] msk,
		input int lim);
		int n;
		n = 0;
		while ((st & msk) !== (want & msk) && n < lim) begin
			@(posedge clock_i);
			n++;
		end
		chk("port state", {9'h0, want & msk}, {9'h0, st & msk});
	endtask

	task end_of_test;
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Hang guard well above the expected run length
	initial begin
		repeat (90000) @(posedge clock_i);
		errors++;
		end_of_test;
	end

	initial begin
		logic [31:0] rd;
		logic [13:0] d;
		logic [7:0] c;
		rd = $urandom(32'h503F);
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		wait_st({1'b1, 22'h0}, 23'h7FFF00, 1);
		ahb(1'b0, `EXP_OFF_CTRL, 32'h0, rd);
		chk("ctrl reset", 32'h0300, rd);
		ahb(1'b0, 8'h20, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		// Local then remote: image and coil latencies
		for (int m = 0; m < 2; m++) begin
			d = 14'($urandom);
			c = 8'($urandom);
			ahb(1'b1, `EXP_OFF_CTRL, 32'h0300 | m, rd);
			data <= d;
			on <= 1'b1;
			ahb(1'b1, `EXP_OFF_COILS, {24'h0, c}, rd);
			wait_st({15'h0, c}, 23'hFF, m ? 460 : 260);
			wait_st({1'b0, d, c}, 23'h7FFFFF, m ? 4400 : 2400);
			ahb(1'b0, `EXP_OFF_IMAGE, 32'h0, rd);
			chk("image", {14'h0, 4'h8, d}, rd);
		end
		chk("peer frame", 32'h0, {31'h0, peer_bad});
		// Timeout off: only the stale-data watchdog may drop the link
		ahb(1'b1, `EXP_OFF_CTRL, 32'h0, rd);
		bad <= 1'b1;
		repeat (1400) @(posedge clock_i);
		chk("held", 32'h0, {31'h0, expansion_health_input_o});
		wait_st({1'b1, 22'h0}, 23'h7FFF00, 1200);
		bad <= 1'b0;
		wait_st({1'b0, 22'h0}, 23'h400000, 1000);
		ahb(1'b1, `EXP_OFF_CTRL, 32'h0301, rd);
		// Broken frames until the link times out
		bad <= 1'b1;
		wait_st({1'b1, 22'h0}, 23'h7FFF00, 4400);
		on <= 1'b0;
		// Let a frame still in flight finish before status is cleared
		repeat (100) @(posedge clock_i);
		ahb(1'b1, `EXP_OFF_MASK, 32'h1, rd);
		ahb(1'b0, `EXP_OFF_STATUS, 32'h0, rd);
		chk("status", 32'h7, rd);
		repeat (2) @(posedge clock_i);
		chk("irq on", 32'h1, {31'h0, irq_o});
		ahb(1'b1, `EXP_OFF_STATUS, 32'h7, rd);
		repeat (2) @(posedge clock_i);
		chk("irq off", 32'h0, {31'h0, irq_o});
		ahb(1'b0, `EXP_OFF_STATUS, 32'h0, rd);
		chk("status clr", 32'h0, rd);
		end_of_test;
	end
endmodule // tb
